// [rtl/rsc_ctl_if.sv]
// Interface carrying reset decisions between the synchroniser and the core
`timescale 1ns/1ns
interface rsc_ctl_if;
  logic hold_outputs;
  logic clear_regs;
  logic in_bus_reset;
  modport source (output hold_outputs, output clear_regs, output in_bus_reset);
  modport sink (input hold_outputs, input clear_regs, input in_bus_reset);
endinterface : rsc_ctl_if

// [rtl/rsc_params.svh]
// Constants for the reset and suspend control block
// Functional notes
// - Global reset tri-states outputs, clears registers
// - Suspend keeps registers under global reset
// - Bus reset tri-states outputs, clears registers; the code clears the supply codes but keeps the event enable and pending flags
// - Event output during bus reset only if enabled
// - Default state after bus reset release
// - Suspend keeps registers under bus reset
// - Bus signals sampled on rising clock edge
// - Drive two-bit main supply control pair
// - Drive two-bit programming supply control pair
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
`define RSC_VCC_RESET 2'h0
`define RSC_VPP_RESET 2'h0
`define RSC_PME_ENABLE_RESET 1'h0
`define RSC_VCC_BIT0 0
`define RSC_VCC_BIT1 1
`endif

// [rtl/rsc_pkg.sv]
// Types for the reset and suspend control block
package rsc_pkg;
  typedef enum logic [1:0] {
    rsc_run,
    rsc_held,
    rsc_frozen
  } rsc_mode_type;
  typedef struct packed {
    logic [1:0] vcc;
    logic [1:0] vpp;
    logic pme_enable;
    logic pme_pending;
  } rsc_regs_type;
endpackage : rsc_pkg

// [rtl/rsc_reset_sync.sv]
// Synchronises reset and suspend pins and decides hold and clear
`timescale 1ns/1ns
module rsc_reset_sync
  import rsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic global_reset_in_n,
  input wire logic bus_reset_in_n,
  input wire logic suspend_in_n,
  rsc_ctl_if.source ctl
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
  } rsc_sync_type;
  rsc_sync_type state;
  rsc_sync_type next_state;
  logic glob_seen;
  logic bus_seen;
  logic susp_seen;

  // Two flops per pin on the raw levels; only the second stage is used
  always_comb begin
    next_state = state;
    next_state.meta = {suspend_in_n, bus_reset_in_n, global_reset_in_n};
    next_state.sync = state.meta;
  end

  // Reset leaves both stages at the released level, so no false reset follows
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= '1;
    end else begin
      state <= next_state;
    end
  end

  // Pins are active low; decode only after the second stage
  assign glob_seen = ~state.sync[0];
  assign bus_seen = ~state.sync[1];
  assign susp_seen = ~state.sync[2];
  // Either reset floats the outputs; suspend blocks the clearing and masks the bus reset flag
  assign ctl.hold_outputs = glob_seen | bus_seen;
  assign ctl.clear_regs = (glob_seen | bus_seen) & ~susp_seen;
  assign ctl.in_bus_reset = bus_seen & ~glob_seen & ~susp_seen;
endmodule : rsc_reset_sync

// [rtl/rsc_top.sv]
// Reset and suspend control with card power switch control outputs
`timescale 1ns/1ns
`include "rsc_params.svh"
module rsc_top
  import rsc_pkg::*;
#(
  // Width of each supply control code; the pin pairs carry exactly two bits
  parameter int unsigned CODE_WIDTH = 2
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic global_reset_in_n,
  input wire logic bus_reset_in_n,
  input wire logic suspend_in_n,
  input wire logic set_valid,
  input wire logic [CODE_WIDTH-1:0] set_vcc,
  input wire logic [CODE_WIDTH-1:0] set_vpp,
  input wire logic set_pme_enable,
  input wire logic pme_event,
  output logic card_vcc_ctl_bit0,
  output logic card_vcc_ctl_bit1,
  output logic card_vcc_ctl_oe_n,
  output logic card_vpp_ctl_bit0,
  output logic card_vpp_ctl_bit1,
  output logic card_vpp_ctl_oe_n,
  output logic pme_out_n,
  output logic pme_oe_n,
  output logic [1:0] mode
);
  typedef struct packed {
    rsc_regs_type regs;
    logic [1:0] vcc_pin;
    logic [1:0] vpp_pin;
    logic pins_oe_n;
    logic pme_out_n;
    logic pme_oe_n;
    rsc_mode_type mode;
  } rsc_state_type;
  rsc_state_type state;
  rsc_state_type next_state;
  rsc_ctl_if ctl ();

  //////////////////////////////////////////////////////////////////////////////
  // Refuse code widths that the fixed pin pairs cannot carry
  if (CODE_WIDTH != 2) begin : g_width_check
    $error("supply control code width must be two");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and reset decisions
  rsc_reset_sync u_rsc_reset_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .global_reset_in_n(global_reset_in_n),
    .bus_reset_in_n(bus_reset_in_n),
    .suspend_in_n(suspend_in_n),
    .ctl(ctl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state: register updates and pin drive
  always_comb begin
    next_state = state;
    // A global reset clears all; a bus reset keeps the event context
    if (ctl.clear_regs) begin
      next_state.regs.vcc = `RSC_VCC_RESET;
      next_state.regs.vpp = `RSC_VPP_RESET;
      if (!ctl.in_bus_reset) begin
        next_state.regs.pme_enable = `RSC_PME_ENABLE_RESET;
        next_state.regs.pme_pending = 1'b0;
      end else if (pme_event) begin
        next_state.regs.pme_pending = 1'b1; // Event context kept over bus reset
      end
    end else if (!ctl.hold_outputs) begin
      if (set_valid) begin
        next_state.regs.vcc = set_vcc;
        next_state.regs.vpp = set_vpp;
        next_state.regs.pme_enable = set_pme_enable;
      end
      next_state.regs.pme_pending = pme_event;
    end
    // Suspended resets leave regs untouched
    next_state.vcc_pin = next_state.regs.vcc;
    next_state.vpp_pin = next_state.regs.vpp;
    next_state.pins_oe_n = ctl.hold_outputs;
    next_state.pme_out_n = ~(next_state.regs.pme_pending & next_state.regs.pme_enable);
    // Only a bus reset lets an enabled event output go on driving
    if (ctl.in_bus_reset) begin
      next_state.pme_oe_n = ~next_state.regs.pme_enable;
    end else begin
      next_state.pme_oe_n = ctl.hold_outputs | ~next_state.regs.pme_enable;
    end
    // Mode code: run, held in a clearing reset, frozen in a suspended reset
    case ({ctl.hold_outputs, ctl.clear_regs})
      2'b11: next_state.mode = rsc_held;
      2'b10: next_state.mode = rsc_frozen;
      default: next_state.mode = rsc_run;
    endcase
  end

  // System reset floats every output, as a pin reset would
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= '0;
      state.pins_oe_n <= 1'b1;
      state.pme_out_n <= 1'b1;
      state.pme_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign card_vcc_ctl_bit0 = state.vcc_pin[`RSC_VCC_BIT0];
  assign card_vcc_ctl_bit1 = state.vcc_pin[`RSC_VCC_BIT1];
  assign card_vpp_ctl_bit0 = state.vpp_pin[`RSC_VCC_BIT0];
  assign card_vpp_ctl_bit1 = state.vpp_pin[`RSC_VCC_BIT1];
  assign card_vcc_ctl_oe_n = state.pins_oe_n;
  assign card_vpp_ctl_oe_n = state.pins_oe_n;
  assign pme_out_n = state.pme_out_n;
  assign pme_oe_n = state.pme_oe_n;
  assign mode = state.mode;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_reset_seen;
    ctl.hold_outputs;
  endsequence
  chk_float_on_reset: assert property (@(posedge sys_clk) disable iff (reset)
    s_reset_seen |=> card_vcc_ctl_oe_n && card_vpp_ctl_oe_n)
    else $error("outputs driven during reset");
  chk_clear_regs: assert property (@(posedge sys_clk) disable iff (reset)
    ctl.clear_regs |=> state.regs.vcc == `RSC_VCC_RESET && state.regs.vpp == `RSC_VPP_RESET)
    else $error("registers not cleared");
  chk_suspend_keep: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.hold_outputs && !ctl.clear_regs) |=> $stable(state.regs))
    else $error("registers changed in suspend");
  chk_suspend_float: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.hold_outputs && !ctl.clear_regs) |=> pme_oe_n && card_vcc_ctl_oe_n)
    else $error("outputs driven in suspended reset");
  chk_pme_gate: assert property (@(posedge sys_clk) disable iff (reset)
    !pme_oe_n |-> state.regs.pme_enable)
    else $error("event driven while disabled");
  chk_default_after: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.clear_regs ##1 !ctl.hold_outputs) |=> mode == rsc_run)
    else $error("not default after release");
  chk_vcc_drive: assert property (@(posedge sys_clk) disable iff (reset)
    !card_vcc_ctl_oe_n |-> {card_vcc_ctl_bit1, card_vcc_ctl_bit0} == state.regs.vcc)
    else $error("main supply pins mismatch");
  chk_vpp_drive: assert property (@(posedge sys_clk) disable iff (reset)
    !card_vpp_ctl_oe_n |-> {card_vpp_ctl_bit1, card_vpp_ctl_bit0} == state.regs.vpp)
    else $error("programming supply pins mismatch");
  sequence s_global_pin_held;
    $fell(global_reset_in_n) ##1 !global_reset_in_n [*2];
  endsequence
  chk_sync_delay: assert property (@(posedge sys_clk) disable iff (reset)
    s_global_pin_held |=> card_vcc_ctl_oe_n)
    else $error("reset pin not taken in time");

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the mode code, on what a global reset clears and on floating outputs
  chk_held_mode: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.hold_outputs && ctl.clear_regs) |=> mode == rsc_held)
    else $error("mode not held during clearing reset");
  chk_frozen_mode: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.hold_outputs && !ctl.clear_regs) |=> mode == rsc_frozen)
    else $error("mode not frozen during suspended reset");
  chk_global_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.clear_regs && !ctl.in_bus_reset) |=> !state.regs.pme_pending &&
      state.regs.pme_enable == `RSC_PME_ENABLE_RESET)
    else $error("event state survived a global reset");
  chk_event_float: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.hold_outputs && !ctl.in_bus_reset) |=> pme_oe_n)
    else $error("event output driven during reset");
  chk_suspend_vpp_float: assert property (@(posedge sys_clk) disable iff (reset)
    (ctl.hold_outputs && !ctl.clear_regs) |=> card_vpp_ctl_oe_n)
    else $error("programming supply pins driven in suspend");

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the event output and its enable while the bus reset holds
  sequence s_bus_reset_enabled;
    ctl.in_bus_reset && state.regs.pme_enable;
  endsequence
  sequence s_bus_reset_disabled;
    ctl.in_bus_reset && !state.regs.pme_enable;
  endsequence
  chk_pme_drive_bus: assert property (@(posedge sys_clk) disable iff (reset)
    s_bus_reset_enabled |=> !pme_oe_n)
    else $error("enabled event output floated in bus reset");
  chk_pme_quiet_bus: assert property (@(posedge sys_clk) disable iff (reset)
    s_bus_reset_disabled |=> pme_oe_n && pme_out_n)
    else $error("disabled event output driven in bus reset");
  chk_pme_context: assert property (@(posedge sys_clk) disable iff (reset)
    ctl.in_bus_reset |=> $stable(state.regs.pme_enable))
    else $error("event enable lost over bus reset");

  //////////////////////////////////////////////////////////////////////////////
  // Checks on loading the supply control codes
  sequence s_code_load;
    set_valid && !ctl.hold_outputs;
  endsequence
  chk_vcc_load: assert property (@(posedge sys_clk) disable iff (reset)
    s_code_load |=> {card_vcc_ctl_bit1, card_vcc_ctl_bit0} == $past(set_vcc))
    else $error("main supply code not loaded");
  chk_vpp_load: assert property (@(posedge sys_clk) disable iff (reset)
    s_code_load |=> {card_vpp_ctl_bit1, card_vpp_ctl_bit0} == $past(set_vpp))
    else $error("programming supply code not loaded");

  //////////////////////////////////////////////////////////////////////////////
  // Checks on release and on bus pin timing through the synchroniser
  sequence s_release;
    ctl.hold_outputs ##1 !ctl.hold_outputs;
  endsequence
  sequence s_bus_pin_held;
    $fell(bus_reset_in_n) ##1 !bus_reset_in_n [*2];
  endsequence
  chk_drive_after: assert property (@(posedge sys_clk) disable iff (reset)
    s_release |=> !card_vcc_ctl_oe_n && !card_vpp_ctl_oe_n)
    else $error("outputs still floating after release");
  chk_bus_pin_delay: assert property (@(posedge sys_clk) disable iff (reset)
    s_bus_pin_held |=> card_vpp_ctl_oe_n)
    else $error("bus reset pin not taken in time");
endmodule : rsc_top

// [sim/reset_suspend_control_tb.sv]
// Self-checking bench for the reset and suspend control block
`timescale 1ns/1ns
module reset_suspend_control_tb;
  logic sys_clk = 1'b0, reset = 1'b1, boot = 1'b0, want_bus = 1'b0, want_susp = 1'b0;
  logic set_valid = 1'b0, set_pme_enable = 1'b0, pme_event = 1'b0;
  logic [1:0] set_vcc = 2'h0, set_vpp = 2'h0;
  wire logic global_reset_in_n, bus_reset_in_n, suspend_in_n;
  wire logic vc1, vc0, vco, vp1, vp0, vpo, pme_out_n, pme_oe_n;
  wire logic [1:0] mode;
  wire logic [7:0] obs = {mode, vco, vpo, vc1, vc0, vp1, vp0};
  wire logic [7:0] pme = {6'h00, pme_oe_n, pme_out_n};
  int n_fail = 0, tests_run = 0;
  // Rows hold codes to load beside the pin pattern that they should give
  logic [11:0] rows [4] = '{12'h606, 12'h909, 12'hf0f, 12'h000};
  rsc_host_model u_rsc_host_model (.sys_clk, .boot, .want_bus, .want_susp,
    .global_reset_in_n, .bus_reset_in_n, .suspend_in_n);
  rsc_top u_rsc_top (.sys_clk, .reset, .global_reset_in_n, .bus_reset_in_n,
    .suspend_in_n, .set_valid, .set_vcc, .set_vpp, .set_pme_enable, .pme_event,
    .card_vcc_ctl_bit0(vc0), .card_vcc_ctl_bit1(vc1), .card_vcc_ctl_oe_n(vco),
    .card_vpp_ctl_bit0(vp0), .card_vpp_ctl_bit1(vp1), .card_vpp_ctl_oe_n(vpo),
    .pme_out_n, .pme_oe_n, .mode);
  // Clock of 40 ns period
  always #20 sys_clk = ~sys_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [1:0] v, input logic [1:0] p, input logic e);
    set_valid = 1'b1;
    set_vcc = v;
    set_vpp = p;
    set_pme_enable = e;
    cyc(1);
    set_valid = 1'b0;
    cyc(2);
  endtask : put
  task automatic close_out;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  // Main sequence
  initial begin
    cyc(1);
    chk(obs, 8'h30);
    chk(pme, 8'h03);
    cyc(1);
    reset = 1'b0;
    cyc(2);
    chk(obs, 8'h00);
    foreach (rows[i]) begin
      put(rows[i][11:10], rows[i][9:8], 1'b0);
      chk(obs, rows[i][7:0]);
    end
    put(2'h3, 2'h3, 1'b1);
    pme_event = 1'b1;
    cyc(3);
    want_bus = 1'b1;
    cyc(5);
    put(2'h1, 2'h1, 1'b1);
    chk(obs, 8'h70);
    chk(pme, 8'h00);
    want_bus = 1'b0;
    cyc(5);
    chk(obs, 8'h00);
    put(2'h0, 2'h0, 1'b0);
    want_bus = 1'b1;
    cyc(5);
    chk(pme & 8'h02, 8'h02);
    want_bus = 1'b0;
    cyc(5);
    for (int k = 0; k < 2; k++) begin
      put(2'h2, 2'h1, 1'b0);
      want_susp = 1'b1;
      cyc(5);
      boot = (k == 0);
      want_bus = (k == 1);
      cyc(5);
      chk({4'h0, obs[7:4]}, 8'h0b);
      {boot, want_bus} = 2'h0;
      cyc(5);
      want_susp = 1'b0;
      cyc(5);
      chk(obs, 8'h09);
    end
    put(2'h3, 2'h3, 1'b1);
    boot = 1'b1;
    cyc(5);
    chk(obs, 8'h70);
    chk(pme, 8'h03);
    boot = 1'b0;
    cyc(5);
    chk(obs, 8'h00);
    // System reset in mid-run floats the pins and clears loaded codes
    put(2'h1, 2'h2, 1'b1);
    reset = 1'b1;
    cyc(1);
    chk(obs, 8'h30);
    chk(pme, 8'h03);
    reset = 1'b0;
    cyc(2);
    chk(obs, 8'h00);
    chk(pme, 8'h03);
    close_out();
  end
endmodule : reset_suspend_control_tb

// [sim/rsc_host_model.sv]
// Host side model that drives the reset and suspend pins
`timescale 1ns/1ns
module rsc_host_model (
  input wire logic sys_clk,
  input wire logic boot,
  input wire logic want_bus,
  input wire logic want_susp,
  output logic global_reset_in_n,
  output logic bus_reset_in_n,
  output logic suspend_in_n
);
  // Pins follow the host's wishes just after each rising edge, so the next
  // rising edge samples them settled and no update races the bench
  always @(posedge sys_clk) begin
    global_reset_in_n <= !boot;
    bus_reset_in_n <= !want_bus;
    suspend_in_n <= !want_susp;
  end
endmodule : rsc_host_model
